// File: rtl/rtca_top.sv
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "rtca_cfg.svh"
module rtca_top #(
    parameter int FIELDS = rtca_pkg::RTCA_FIELDS
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_b,
    // Register port
    input  wire rtca_pkg::rtca_addr_t reg_addr,
    input  wire rtca_pkg::rtca_byte_t reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output rtca_pkg::rtca_byte_t  reg_rdata,
    // Running counters, BCD, same clock domain
    input  wire logic [6:0]       second_counter,
    input  wire logic [6:0]       minute_counter,
    input  wire logic [5:0]       hour_counter,
    input  wire logic [2:0]       weekday_counter,
    input  wire logic [5:0]       date_counter,
    input  wire logic [4:0]       month_counter,
    input  wire logic             counter_update,
    // Carry detection
    input  wire logic             counter_read,
    input  wire logic             second_carry,
    input  wire logic             sixty_four_hz_carry,
    // Interrupt requests
    output logic                  carry_irq,
    output logic                  alarm_irq
);
    import rtca_pkg::*;

    typedef struct packed {
        logic [FIELDS-1:0][7:0] alarm;
        logic                   carry_seen;
        logic                   carry_irq_on;
        logic                   alarm_irq_on;
        logic                   alarm_match_seen;
        logic                   carry_irq;
        logic                   alarm_irq;
        rtca_byte_t             rdata;
        logic                   por_done;
    } rtca_top_s;

    rtca_top_s st_r;
    rtca_top_s st_nxt;

    rtca_cmp_if cmp_bus ();
    logic       match_rise;
    logic [FIELDS-1:0][7:0] value_mask;
    logic [47:0] counters;
    logic        manual_rst;
    logic        standby;
    rtca_byte_t  flag_rd;

    assign value_mask = {`RTCA_MASK_MONTH, `RTCA_MASK_DATE,
                         `RTCA_MASK_WEEKDAY, `RTCA_MASK_HOUR,
                         `RTCA_MASK_MINUTE, `RTCA_MASK_SECOND};
    assign counters = {3'h0, month_counter, 2'h0, date_counter,
                       5'h0, weekday_counter, 2'h0, hour_counter,
                       1'h0, minute_counter, 1'h0, second_counter};

    genvar gi;
    generate
        for (gi = 0; gi < FIELDS; gi = gi + 1) begin : g_pack
            assign cmp_bus.alarm_value[gi*8 +: 8] =
                {1'b0, st_r.alarm[gi][6:0]};
            assign cmp_bus.compare_on[gi] =
                st_r.alarm[gi][`RTCA_BIT_COMPARE_ON];
        end
    endgenerate
    assign cmp_bus.counter_value = counters;

    rtca_compare #(
        .FIELDS (FIELDS)
    ) u_compare (
        .cmp (cmp_bus.cmp)
    );

    rtca_edge u_edge (
        .sys_clk    (sys_clk),
        .rst_b      (rst_b),
        .level_in   (cmp_bus.all_match),
        .sample_en  (counter_update),
        .rise_pulse (match_rise)
    );

    // Manual reset and standby are strobes from software control.
    assign manual_rst = reg_wr && (reg_addr == `RTCA_ADDR_RESET_CTRL) &&
                        reg_wdata[`RTCA_BIT_MANUAL_RESET];
    assign standby = reg_wr && (reg_addr == `RTCA_ADDR_RESET_CTRL) &&
                     reg_wdata[`RTCA_BIT_STANDBY];

    always_comb begin
        flag_rd = 8'h00;
        flag_rd[`RTCA_BIT_CARRY_SEEN]   = st_r.carry_seen;
        flag_rd[`RTCA_BIT_CARRY_IRQ_ON] = st_r.carry_irq_on;
        flag_rd[`RTCA_BIT_ALARM_IRQ_ON] = st_r.alarm_irq_on;
        flag_rd[`RTCA_BIT_ALARM_MATCH]  = st_r.alarm_match_seen;
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = 8'h00;
        st_nxt.por_done = 1'b1;

        // Power-on: only the enable bits get a defined value.
        if (!st_r.por_done) begin
            for (int i = 0; i < FIELDS; i++) begin
                st_nxt.alarm[i][`RTCA_BIT_COMPARE_ON] = 1'b0;
            end
        end

        if (reg_wr) begin
            case (reg_addr)
                `RTCA_ADDR_SECOND_ALARM, `RTCA_ADDR_MINUTE_ALARM,
                `RTCA_ADDR_HOUR_ALARM, `RTCA_ADDR_WEEKDAY_ALARM,
                `RTCA_ADDR_DATE_ALARM, `RTCA_ADDR_MONTH_ALARM: begin
                    st_nxt.alarm[reg_addr[2:0]] =
                        reg_wdata & {1'b1, value_mask[reg_addr[2:0]][6:0]};
                end
                `RTCA_ADDR_FLAG_CONTROL: begin
                    st_nxt.carry_seen =
                        reg_wdata[`RTCA_BIT_CARRY_SEEN];
                    st_nxt.carry_irq_on = reg_wdata[`RTCA_BIT_CARRY_IRQ_ON];
                    st_nxt.alarm_irq_on = reg_wdata[`RTCA_BIT_ALARM_IRQ_ON];
                    if (!reg_wdata[`RTCA_BIT_ALARM_MATCH]) begin
                        st_nxt.alarm_match_seen = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        if (reg_rd) begin
            case (reg_addr)
                `RTCA_ADDR_SECOND_ALARM, `RTCA_ADDR_MINUTE_ALARM,
                `RTCA_ADDR_HOUR_ALARM, `RTCA_ADDR_WEEKDAY_ALARM,
                `RTCA_ADDR_DATE_ALARM, `RTCA_ADDR_MONTH_ALARM: begin
                    st_nxt.rdata = st_r.alarm[reg_addr[2:0]];
                end
                `RTCA_ADDR_FLAG_CONTROL: begin
                    st_nxt.rdata = flag_rd;
                end
                default: begin
                    st_nxt.rdata = 8'h00;
                end
            endcase
        end

        // Hardware sets win over a same-cycle flag/control write clear; standby below wins over both, manual reset only over the alarm match set.
        if (counter_read && (second_carry || sixty_four_hz_carry)) begin
            st_nxt.carry_seen = 1'b1;
        end
        if (match_rise) begin
            st_nxt.alarm_match_seen = 1'b1;
        end

        // Manual reset keeps the carry flag and the alarm fields.
        if (manual_rst) begin
            st_nxt.carry_irq_on     = 1'b0;
            st_nxt.alarm_irq_on     = 1'b0;
            st_nxt.alarm_match_seen = 1'b0;
        end
        if (standby) begin
            st_nxt.carry_seen       = st_r.carry_seen;
            st_nxt.alarm_match_seen = st_r.alarm_match_seen;
        end

        st_nxt.carry_irq = st_nxt.carry_seen && st_nxt.carry_irq_on;
        st_nxt.alarm_irq = st_nxt.alarm_match_seen &&
                           st_nxt.alarm_irq_on;
    end

    // The alarm values are not cleared by rst_b; only their enables are,
    // while rst_b is low and again one cycle after release, so stored values survive a reset pulse.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            st_r.carry_seen       <= 1'b0;
            st_r.carry_irq_on     <= 1'b0;
            st_r.alarm_irq_on     <= 1'b0;
            st_r.alarm_match_seen <= 1'b0;
            st_r.carry_irq        <= 1'b0;
            st_r.alarm_irq        <= 1'b0;
            st_r.rdata            <= 8'h00;
            st_r.por_done         <= 1'b0;
            for (int i = 0; i < FIELDS; i++) begin
                st_r.alarm[i][`RTCA_BIT_COMPARE_ON] <= 1'b0;
            end
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign carry_irq = st_r.carry_irq;
    assign alarm_irq = st_r.alarm_irq;
endmodule

// File: rtl/rtca_cfg.svh
`ifndef RTCA_CFG_SVH
`define RTCA_CFG_SVH

// Register indices on the plain register port (byte-wide registers).
`define RTCA_ADDR_SECOND_ALARM  4'h0
`define RTCA_ADDR_MINUTE_ALARM  4'h1
`define RTCA_ADDR_HOUR_ALARM    4'h2
`define RTCA_ADDR_WEEKDAY_ALARM 4'h3
`define RTCA_ADDR_DATE_ALARM    4'h4
`define RTCA_ADDR_MONTH_ALARM   4'h5
`define RTCA_ADDR_FLAG_CONTROL  4'h6
`define RTCA_ADDR_RESET_CTRL    4'h7

// Field positions.
`define RTCA_BIT_COMPARE_ON     7
`define RTCA_BIT_CARRY_SEEN     7
`define RTCA_BIT_CARRY_IRQ_ON   4
`define RTCA_BIT_ALARM_IRQ_ON   3
`define RTCA_BIT_ALARM_MATCH    0
`define RTCA_BIT_MANUAL_RESET   0
`define RTCA_BIT_STANDBY        1

// Writable value masks per alarm field and for flag/control (reserved bits read zero).
`define RTCA_MASK_SECOND        8'h7F
`define RTCA_MASK_MINUTE        8'h7F
`define RTCA_MASK_HOUR          8'h3F
`define RTCA_MASK_WEEKDAY       8'h07
`define RTCA_MASK_DATE          8'h3F
`define RTCA_MASK_MONTH         8'h1F
`define RTCA_MASK_FLAG_CONTROL  8'h99

// Reset values.
`define RTCA_RST_FLAG_CONTROL   8'h00
`define RTCA_RST_ALARM          8'h00

`endif

// File: rtl/rtca_pkg.sv
package rtca_pkg;
    parameter int RTCA_FIELDS = 6;
    typedef logic [7:0] rtca_byte_t;
    typedef logic [3:0] rtca_addr_t;
    typedef enum logic [1:0] {
        RTCA_RUN     = 2'b00,
        RTCA_STANDBY = 2'b01
    } rtca_mode_e;
endpackage

// File: rtl/rtca_cmp_if.sv
`timescale 1ns/1ps
// Alarm values and counters that travel between the top and the comparator.
interface rtca_cmp_if;
    logic [47:0] alarm_value;
    logic [5:0]  compare_on;
    logic [47:0] counter_value;
    logic        all_match;
    modport top (output alarm_value, output compare_on,
                 output counter_value, input all_match);
    modport cmp (input alarm_value, input compare_on,
                 input counter_value, output all_match);
endinterface

// File: rtl/rtca_compare.sv
`timescale 1ns/1ps
module rtca_compare #(
    parameter int FIELDS = 6
) (
    // Comparison data
    rtca_cmp_if.cmp cmp
);
    import rtca_pkg::*;
    logic [FIELDS-1:0] field_ok;

    genvar gi;
    generate
        for (gi = 0; gi < FIELDS; gi = gi + 1) begin : g_field
            // A disabled field always agrees.
            assign field_ok[gi] = !cmp.compare_on[gi] ||
                (cmp.alarm_value[gi*8 +: 8] ==
                 cmp.counter_value[gi*8 +: 8]);
        end
    endgenerate

    // An alarm needs at least one enabled field.
    assign cmp.all_match = (|cmp.compare_on) && (&field_ok);
endmodule

// File: rtl/rtca_edge.sv
`timescale 1ns/1ps
module rtca_edge (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_b,
    // Level in, rising pulse out
    input  wire logic level_in,
    input  wire logic sample_en,
    output logic      rise_pulse
);
    import rtca_pkg::*;
    typedef struct packed {
        logic last;
        logic rise;
    } rtca_edge_s;
    rtca_edge_s st_r;
    rtca_edge_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.rise = 1'b0;
        if (sample_en) begin
            st_nxt.last = level_in;
            st_nxt.rise = level_in && !st_r.last;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rise_pulse = st_r.rise;
endmodule

// File: bench/rtca_assertions.sv
`timescale 1ns/1ps
`include "rtca_cfg.svh"
module rtca_assertions #(
    parameter int FIELDS = 6
) (
    // Clock and reset
    input wire logic                 sys_clk,
    input wire logic                 rst_b,
    // Register port
    input wire rtca_pkg::rtca_addr_t reg_addr,
    input wire rtca_pkg::rtca_byte_t reg_wdata,
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire rtca_pkg::rtca_byte_t reg_rdata,
    // Events and requests
    input wire logic                 counter_update,
    input wire logic                 counter_read,
    input wire logic                 second_carry,
    input wire logic                 sixty_four_hz_carry,
    input wire logic                 carry_irq,
    input wire logic                 alarm_irq
);
    import rtca_pkg::*;
    logic cie_r;
    logic aie_r;
    logic fc_wr;
    logic rst_wr;
    logic carry_ev;
    logic ctl_wr;
    assign fc_wr = reg_wr && reg_addr == `RTCA_ADDR_FLAG_CONTROL;
    // A standby strobe freezes the flags, so a carry beside it is dropped.
    assign ctl_wr = reg_wr && reg_addr == `RTCA_ADDR_RESET_CTRL;
    assign rst_wr = reg_wr && reg_addr == `RTCA_ADDR_RESET_CTRL && reg_wdata[0];
    assign carry_ev = counter_read && (second_carry || sixty_four_hz_carry);
    // The enables are invisible at the pins, so a shadow copy is kept here.
    always_ff @(posedge sys_clk) begin
        if (!rst_b || rst_wr) begin
            cie_r <= 1'b0;
            aie_r <= 1'b0;
        end else if (fc_wr) begin
            cie_r <= reg_wdata[4];
            aie_r <= reg_wdata[3];
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    AST_RESET_QUIET: assert property (disable iff (1'b0) !rst_b |=>
        reg_rdata == 8'h00 && !carry_irq && !alarm_irq) else $error("reset");
    AST_RSVD_ZERO: assert property ($past(reg_rd) && $past(reg_addr) == 4'h6
        |-> (reg_rdata & 8'h66) == 8'h00) else $error("reserved bits");
    AST_CARRY_SET: assert property (carry_ev && cie_r
        && !fc_wr && !ctl_wr |=> carry_irq) else $error("carry not flagged");
    AST_CARRY_MASK: assert property (!cie_r |-> !carry_irq)
        else $error("carry irq while off");
    AST_ALARM_MASK: assert property (!aie_r |-> !alarm_irq)
        else $error("alarm irq while off");
    AST_CARRY_CLEAR: assert property (fc_wr && !reg_wdata[7] && !carry_ev
        |=> !carry_irq) else $error("carry not cleared");
    AST_CARRY_WSET: assert property (fc_wr && reg_wdata[7] && reg_wdata[4]
        |=> carry_irq) else $error("carry not set by write");
    AST_ALARM_CLEAR: assert property (fc_wr && !reg_wdata[0]
        && !$past(counter_update) |=> !alarm_irq) else $error("alarm kept");
    AST_ALARM_HOLD: assert property (alarm_irq && !rst_wr
        && !(fc_wr && !(reg_wdata[0] && reg_wdata[3])) |=> alarm_irq)
        else $error("alarm dropped");
    AST_MANUAL_RESET: assert property (rst_wr |=> !carry_irq && !alarm_irq)
        else $error("manual reset");
    cover property ($rose(alarm_irq));
    cover property ($rose(carry_irq));
    cover property (rst_wr);
endmodule
bind rtca_top rtca_assertions #(.FIELDS(FIELDS)) u_chk (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .counter_update(counter_update),
    .counter_read(counter_read), .second_carry(second_carry),
    .sixty_four_hz_carry(sixty_four_hz_carry), .carry_irq(carry_irq),
    .alarm_irq(alarm_irq));

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import rtca_pkg::*;
    logic       sys_clk, rst_b, reg_wr, reg_rd, counter_update, counter_read;
    logic       second_carry, sixty_four_hz_carry, carry_irq, alarm_irq;
    rtca_addr_t reg_addr;
    rtca_byte_t reg_wdata, reg_rdata;
    logic [6:0] second_counter, minute_counter;
    logic [5:0] hour_counter, date_counter;
    logic [2:0] weekday_counter;
    logic [4:0] month_counter;
    int         num_errors = 0;
    int         checked = 0;
    int         cycles = 0;
    rtca_byte_t mask_exp [6] = '{8'hFF, 8'hFF, 8'hBF, 8'h87, 8'hBF, 8'h9F};
    rtca_byte_t alarm_val [6] = '{8'h59, 8'h00,
        8'h23,
        8'h05,
        8'h31,
        8'h11};

    rtca_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .second_counter(second_counter),
        .minute_counter(minute_counter), .hour_counter(hour_counter),
        .weekday_counter(weekday_counter), .date_counter(date_counter),
        .month_counter(month_counter), .counter_update(counter_update),
        .counter_read(counter_read), .second_carry(second_carry),
        .sixty_four_hz_carry(sixty_four_hz_carry), .carry_irq(carry_irq),
        .alarm_irq(alarm_irq));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic chk8(input string what, input rtca_byte_t exp, got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk1(input string what, input logic exp, got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic wr(input rtca_addr_t a, input rtca_byte_t d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // Bits outside the mask are unwritten alarm values and are not judged.
    task automatic rd(string what, rtca_addr_t a, rtca_byte_t exp, m);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk8(what, exp, reg_rdata & m);
    endtask
    // Counter k misses its alarm by one; k of 6 makes every field match.
    task automatic set_cnt(input int k);
        @(posedge sys_clk);
        second_counter <= 7'(alarm_val[0]) ^ 7'(k == 0);
        minute_counter <= 7'(alarm_val[1]) ^ 7'(k == 1);
        hour_counter <= 6'(alarm_val[2]) ^ 6'(k == 2);
        weekday_counter <= 3'(alarm_val[3]) ^ 3'(k == 3);
        date_counter <= 6'(alarm_val[4]) ^ 6'(k == 4);
        month_counter <= 5'(alarm_val[5]) ^ 5'(k == 5);
        @(posedge sys_clk);
        counter_update <= 1'b1;
        @(posedge sys_clk);
        counter_update <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask
    task automatic carry(input logic rd_on, sec);
        @(posedge sys_clk);
        counter_read <= rd_on;
        second_carry <= sec;
        sixty_four_hz_carry <= !sec;
        @(posedge sys_clk);
        {counter_read, second_carry, sixty_four_hz_carry} <= 3'h0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic settle;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask

    initial begin
        {rst_b, reg_wr, reg_rd, counter_update, counter_read} = 5'h00;
        {second_carry, sixty_four_hz_carry, reg_addr, reg_wdata} = 14'h0000;
        {second_counter, minute_counter, hour_counter} = 20'h00000;
        {weekday_counter, date_counter, month_counter} = 14'h0000;
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rd("flag_control", 4'h6, 8'h00, 8'hFF);
        for (int i = 0; i < 6; i++) begin
            rd("compare_on", 4'(i), 8'h00, 8'h80);
            wr(4'(i), 8'hFF);
            rd("alarm mask", 4'(i), mask_exp[i], 8'hFF);
            wr(4'(i), 8'h80 | alarm_val[i]);
        end
        wr(4'h8, 8'hFF);
        rd("unmapped", 4'h8, 8'h00, 8'hFF);
        wr(4'h6, 8'h99);
        rd("flag_control", 4'h6, 8'h98, 8'hFF);
        chk1("carry_irq", 1'b1, carry_irq);
        wr(4'h6, 8'h08);
        settle;
        chk1("carry_irq", 1'b0, carry_irq);
        for (int k = 0; k < 7; k++) begin
            set_cnt(k);
            chk1("alarm_irq", k == 6, alarm_irq);
        end
        wr(4'h6, 8'h09);
        settle;
        chk1("alarm_irq", 1'b1, alarm_irq);
        wr(4'h6, 8'h08);
        settle;
        chk1("alarm_irq", 1'b0, alarm_irq);
        set_cnt(6);
        chk1("alarm_irq", 1'b0, alarm_irq);
        set_cnt(0);
        wr(4'h0, alarm_val[0]);
        set_cnt(0);
        chk1("alarm_irq", 1'b1, alarm_irq);
        wr(4'h6, 8'h18);
        carry(1'b0, 1'b1);
        chk1("carry_irq", 1'b0, carry_irq);
        carry(1'b1, 1'b1);
        chk1("carry_irq", 1'b1, carry_irq);
        wr(4'h6, 8'h18);
        carry(1'b1, 1'b0);
        chk1("carry_irq", 1'b1, carry_irq);
        set_cnt(1);
        set_cnt(6);
        chk1("alarm_irq", 1'b1, alarm_irq);
        wr(4'h7, 8'h02);
        rd("flag_control", 4'h6, 8'h99, 8'hFF);
        wr(4'h7, 8'h01);
        rd("flag_control", 4'h6, 8'h80, 8'hFF);
        chk1("alarm_irq", 1'b0, alarm_irq);
        // A carry that meets a standby strobe must leave the flag alone.
        wr(4'h6, 8'h00);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= 4'h7;
        reg_wdata <= 8'h02;
        counter_read <= 1'b1;
        second_carry <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        {counter_read, second_carry} <= 2'h0;
        rd("flag_control", 4'h6, 8'h00, 8'hFF);
        rd("hour_alarm", 4'h2, 8'hA3, 8'hFF);
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rd("hour_alarm", 4'h2, 8'h23, 8'hFF);
        rd("flag_control", 4'h6, 8'h00, 8'hFF);
        give_verdict();
    end
endmodule
